// file: rtl/ccad_decode.sv
// memory, port and timer combo chip: address decode, registers, data bus
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - Ten address lines pick words inside the chip while the rom select and up to two chip selects qualify the target.
// - The rom select line separates rom accesses from ram and port-timer accesses.
// - Each of the two chip-select pins is a mask option, either a select input or port b bit five or six.
// - With rom select low, a9 low selects ram and a9 high the port-timer section, a8..a6 naming the chip.
// - In the port-timer section a2 low selects the port registers and a2 high the timer.
// - For the ports a1..a0 pick port a data, port a direction, port b data or port b direction.
// - A timer write loads the count and takes its prescaler of 1, 8, 64 or 1024 from a1..a0.
// - Every timer access takes a3 as the enable of the interrupt onto the port b bit seven pin.
// - A timer read returns the count when a0 is low and the interrupt flag when a0 is high.
// - The data bus is driven only for a read that selects this chip.
// - A direction bit of one drives the pin from the data register, a zero leaves it an input held high.
// - A port data read returns pin levels, stored bits for outputs, and only writes change stored data.
// - Any timer access clears the flag except one in the cycle that raises it.
module ccad_decode
   import ccad_pkg::*;
#(
   parameter bit         CS1_IS_SELECT = 1'b0,
   parameter bit         CS2_IS_SELECT = 1'b0,
   parameter logic [2:0] ROM_KEY       = 3'h1,
   parameter bit         USE_CHIP_ID   = 1'b0,
   parameter logic [2:0] CHIP_ID       = 3'h0,
   parameter logic [7:0] ROM_SEED      = 8'h5a
) (
   input  wire logic      i_mclk,
   input  wire logic      i_resetn,
   input  wire ccad_bus_t i_bus,
   input  wire logic [7:0] i_port_a_pins,
   input  wire logic [7:0] i_port_b_pins,
   output logic [7:0]     o_data,
   output logic           o_data_oe,
   output ccad_pins_t     o_port_a,
   output ccad_pins_t     o_port_b
);

   // ==========================================================
   // decode helpers
   function automatic ccad_target_t decode(input ccad_bus_t b, input logic [7:0] pb);
      logic [2:0] key;
      logic [2:0] msk;
      key = {pb[CCAD_PB_CS2], pb[CCAD_PB_CS1], b.rom_region_select};
      msk = {CS2_IS_SELECT, CS1_IS_SELECT, 1'b1};
      if (!b.valid) begin
         decode = CCAD_T_NONE;
      end else if (((key ^ ROM_KEY) & msk) == 3'h0) begin
         decode = CCAD_T_ROM;
      end else if ((key & msk) != 3'h0) begin
         decode = CCAD_T_NONE;
      end else if (USE_CHIP_ID && (b.addr[8:6] != CHIP_ID)) begin
         decode = CCAD_T_NONE;
      end else if (!b.addr[CCAD_A_IO]) begin
         decode = CCAD_T_RAM;
      end else if (!b.addr[CCAD_A_TIMER]) begin
         decode = CCAD_T_PORT;
      end else begin
         decode = CCAD_T_TIMER;
      end
   endfunction

   // stand-in for the mask pattern of the 1k rom
   function automatic logic [7:0] rom_word(input logic [9:0] a);
      rom_word = a[7:0] ^ {6'h00, a[9:8]} ^ ROM_SEED;
   endfunction

   // outputs read their stored bit, inputs read the pin
   function automatic logic [7:0] pin_view(input logic [7:0] d, input logic [7:0] dir, input logic [7:0] p);
      pin_view = (d & dir) | (p & ~dir);
   endfunction

   // ==========================================================
   // access classification
   ccad_target_t tgt;
   logic         rd_sel;
   logic         port_wr;
   logic [1:0]   rsel;
   logic [7:0]   port_reg [4];
   logic [7:0]   ram_rdata;
   logic [7:0]   t_count;
   logic         t_flag;
   logic         t_irq_en;
   logic [7:0]   rd_word;
   logic [7:0]   s1_word_reg;
   logic         s1_rd_reg;
   logic         s1_ram_reg;
   logic         irq_active;

   assign tgt     = decode(i_bus, i_port_b_pins);
   assign rsel    = i_bus.addr[1:0];
   // rom writes count as no read and hit no register
   assign rd_sel  = i_bus.read && (tgt != CCAD_T_NONE);
   assign port_wr = !i_bus.read && (tgt == CCAD_T_PORT);

   // ==========================================================
   // port data and direction registers
   for (genvar g = 0; g < 4; g++) begin : g_port
      always_ff @(posedge i_mclk or negedge i_resetn) begin
         if (!i_resetn) begin
            port_reg[g] <= CCAD_PORT_RST;
         end else if (port_wr && (rsel == 2'(g))) begin
            port_reg[g] <= i_bus.wdata;
         end
      end
   end

   // ==========================================================
   // ram and timer
   ccad_mem #(
      .AW (CCAD_RAM_AW)
   ) u_ram (
      .i_mclk  (i_mclk),
      .i_we    (!i_bus.read && (tgt == CCAD_T_RAM)),
      .i_addr  (i_bus.addr[CCAD_RAM_AW-1:0]),
      .i_wdata (i_bus.wdata),
      .o_rdata (ram_rdata)
   );

   ccad_timer u_timer (
      .i_mclk    (i_mclk),
      .i_resetn  (i_resetn),
      .i_access  (tgt == CCAD_T_TIMER),
      .i_write   (!i_bus.read && (tgt == CCAD_T_TIMER)),
      .i_div_sel (rsel),
      .i_irq_en  (i_bus.addr[CCAD_A_IRQEN]),
      .i_wdata   (i_bus.wdata),
      .o_count   (t_count),
      .o_flag    (t_flag),
      .o_irq_en  (t_irq_en)
   );

   // ==========================================================
   // read data, sampled at the access edge
   always_comb begin
      rd_word = CCAD_DATA_RST;
      unique case (tgt)
         CCAD_T_NONE,
         CCAD_T_RAM: begin
            rd_word = CCAD_DATA_RST;
         end
         CCAD_T_ROM: begin
            rd_word = rom_word(i_bus.addr);
         end
         CCAD_T_PORT: begin
            unique case (rsel)
               CCAD_PA_DATA: rd_word = pin_view(port_reg[0], port_reg[1], i_port_a_pins);
               CCAD_PB_DATA: rd_word = pin_view(port_reg[2], port_reg[3], i_port_b_pins);
               CCAD_PA_DIR,
               CCAD_PB_DIR:  rd_word = port_reg[rsel];
            endcase
         end
         CCAD_T_TIMER: begin
            // a1 is ignored on reads
            rd_word = i_bus.addr[0] ? {t_flag, 7'h00} : t_count;
         end
      endcase
   end

   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         s1_word_reg <= CCAD_DATA_RST;
         s1_rd_reg   <= 1'b0;
         s1_ram_reg  <= 1'b0;
      end else begin
         s1_word_reg <= rd_word;
         s1_rd_reg   <= rd_sel;
         s1_ram_reg  <= (tgt == CCAD_T_RAM);
      end
   end

   // second stage so the bus pins come straight from flops
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_data    <= CCAD_DATA_RST;
         o_data_oe <= 1'b0;
      end else begin
         o_data    <= s1_ram_reg ? ram_rdata : s1_word_reg;
         o_data_oe <= s1_rd_reg;
      end
   end

   // ==========================================================
   // peripheral pins; inputs idle high through the pull-up level
   assign irq_active = t_flag && t_irq_en;

   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_port_a <= '{level: 8'hff, oe: 8'h00};
      end else begin
         o_port_a.level <= port_reg[0] | ~port_reg[1];
         o_port_a.oe    <= port_reg[1];
      end
   end

   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_port_b <= '{level: 8'hff, oe: 8'h00};
      end else begin
         o_port_b.level <= port_reg[2] | ~port_reg[3];
         o_port_b.oe    <= port_reg[3];
         // select pins are never driven
         if (CS2_IS_SELECT) begin
            o_port_b.oe[CCAD_PB_CS2] <= 1'b0;
         end
         if (CS1_IS_SELECT) begin
            o_port_b.oe[CCAD_PB_CS1] <= 1'b0;
         end
         // active-low interrupt overrides the port bit
         if (irq_active) begin
            o_port_b.level[CCAD_PB_IRQ] <= 1'b0;
            o_port_b.oe[CCAD_PB_IRQ]    <= 1'b1;
         end
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_resetn);

   property p_read_drives;
      rd_sel |-> ##2 o_data_oe;
   endproperty
   a_read_drives: assert property (p_read_drives) else $error("selected read not driven");

   property p_drive_only_reads;
      o_data_oe |-> $past(rd_sel, 2);
   endproperty
   a_drive_only_reads: assert property (p_drive_only_reads) else $error("bus driven without read");

   property p_rom_write_inert;
      (tgt == CCAD_T_ROM && !i_bus.read) |=> $stable({port_reg[0], port_reg[1], port_reg[2], port_reg[3]}) ##1 !o_data_oe;
   endproperty
   a_rom_write_inert: assert property (p_rom_write_inert) else $error("rom write had an effect");

   property p_unselected;
      (tgt == CCAD_T_NONE) |=> $stable({port_reg[0], port_reg[1], port_reg[2], port_reg[3]});
   endproperty
   a_unselected: assert property (p_unselected) else $error("unselected access changed state");

   property p_dir_drives;
      (port_wr && rsel == CCAD_PA_DIR) |-> ##2 o_port_a.oe == $past(i_bus.wdata, 2);
   endproperty
   a_dir_drives: assert property (p_dir_drives) else $error("direction write not on pins");

   property p_rom_read;
      (tgt == CCAD_T_ROM && i_bus.read) |-> ##2 o_data == rom_word($past(i_bus.addr, 2));
   endproperty
   a_rom_read: assert property (p_rom_read) else $error("rom read data wrong");

   property p_flag_read;
      (tgt == CCAD_T_TIMER && i_bus.read && i_bus.addr[0]) |-> ##2 o_data[CCAD_FLAG_BIT] == $past(t_flag, 2);
   endproperty
   a_flag_read: assert property (p_flag_read) else $error("flag read wrong");

   property p_ram_split;
      (tgt == CCAD_T_RAM) |-> !i_bus.addr[CCAD_A_IO] && !i_bus.rom_region_select;
   endproperty
   a_ram_split: assert property (p_ram_split) else $error("ram selected with a9 high");

   property p_timer_split;
      (tgt == CCAD_T_TIMER) |-> i_bus.addr[CCAD_A_IO] && i_bus.addr[CCAD_A_TIMER] && !i_bus.rom_region_select;
   endproperty
   a_timer_split: assert property (p_timer_split) else $error("timer selected off its address");

   property p_pb_data_write;
      (port_wr && rsel == CCAD_PB_DATA) |=> port_reg[2] == $past(i_bus.wdata);
   endproperty
   a_pb_data_write: assert property (p_pb_data_write) else $error("port b data not written");

   property p_pb_dir_drives;
      (port_wr && rsel == CCAD_PB_DIR) |-> ##2 o_port_b.oe[4:0] == $past(i_bus.wdata[4:0], 2);
   endproperty
   a_pb_dir_drives: assert property (p_pb_dir_drives) else $error("port b direction not on pins");

   property p_irq_pin;
      (t_flag && t_irq_en) |=> o_port_b.oe[CCAD_PB_IRQ] && !o_port_b.level[CCAD_PB_IRQ];
   endproperty
   a_irq_pin: assert property (p_irq_pin) else $error("interrupt not on port b bit seven");

   property p_cs_undriven;
      !(CS1_IS_SELECT && o_port_b.oe[CCAD_PB_CS1]) && !(CS2_IS_SELECT && o_port_b.oe[CCAD_PB_CS2]);
   endproperty
   a_cs_undriven: assert property (p_cs_undriven) else $error("chip select pin driven");

   property p_pa_read;
      (tgt == CCAD_T_PORT && i_bus.read && rsel == CCAD_PA_DATA) |->
         ##2 (o_data & $past(port_reg[1], 2)) == $past(port_reg[0] & port_reg[1], 2);
   endproperty
   a_pa_read: assert property (p_pa_read) else $error("output bits of port a read wrong");

   property p_count_read;
      (tgt == CCAD_T_TIMER && i_bus.read && !i_bus.addr[0]) |-> ##2 o_data == $past(t_count, 2);
   endproperty
   a_count_read: assert property (p_count_read) else $error("timer count read wrong");

   c_rom_read: cover property (tgt == CCAD_T_ROM && i_bus.read);
   c_port_write: cover property (port_wr);
   c_timer_read: cover property (tgt == CCAD_T_TIMER && i_bus.read ##2 o_data_oe);
endmodule // ccad_decode
`default_nettype wire

// file: rtl/ccad_pkg.sv
// package: constants and carriers for the combo chip address decoder
package ccad_pkg;

   // ==========================================================
   // address fields
   localparam int CCAD_RAM_AW   = 6;
   localparam int CCAD_A_IO     = 9;
   localparam int CCAD_A_IRQEN  = 3;
   localparam int CCAD_A_TIMER  = 2;
   localparam int CCAD_PB_CS2   = 5;
   localparam int CCAD_PB_CS1   = 6;
   localparam int CCAD_PB_IRQ   = 7;
   localparam int CCAD_FLAG_BIT = 7;

   // ==========================================================
   // port register select on a1..a0
   localparam logic [1:0] CCAD_PA_DATA = 2'h0;
   localparam logic [1:0] CCAD_PA_DIR  = 2'h1;
   localparam logic [1:0] CCAD_PB_DATA = 2'h2;
   localparam logic [1:0] CCAD_PB_DIR  = 2'h3;

   // ==========================================================
   // timer prescale select and reload values (divide minus one)
   localparam logic [1:0] CCAD_DIV_1    = 2'h0;
   localparam logic [1:0] CCAD_DIV_8    = 2'h1;
   localparam logic [1:0] CCAD_DIV_64   = 2'h2;
   localparam logic [1:0] CCAD_DIV_1024 = 2'h3;
   localparam logic [9:0] CCAD_PRE_1    = 10'h000;
   localparam logic [9:0] CCAD_PRE_8    = 10'h007;
   localparam logic [9:0] CCAD_PRE_64   = 10'h03f;
   localparam logic [9:0] CCAD_PRE_1024 = 10'h3ff;

   // ==========================================================
   // values after reset and fixed patterns
   localparam logic [7:0] CCAD_PORT_RST  = 8'h00;
   localparam logic [7:0] CCAD_COUNT_RST = 8'h00;
   localparam logic [7:0] CCAD_WRAP      = 8'hff;
   localparam logic [7:0] CCAD_DATA_RST  = 8'h00;
   localparam int         CCAD_RD_LAT    = 2;

   // ==========================================================
   // types
   typedef enum logic [4:0] {
      CCAD_T_NONE  = 5'b00001,
      CCAD_T_ROM   = 5'b00010,
      CCAD_T_RAM   = 5'b00100,
      CCAD_T_PORT  = 5'b01000,
      CCAD_T_TIMER = 5'b10000
   } ccad_target_t;

   typedef struct packed {
      logic       valid;
      logic       read;
      logic       rom_region_select;
      logic [9:0] addr;
      logic [7:0] wdata;
   } ccad_bus_t;

   typedef struct packed {
      logic [7:0] level;
      logic [7:0] oe;
   } ccad_pins_t;

   function automatic logic [9:0] ccad_prescale(input logic [1:0] sel);
      unique case (sel)
         CCAD_DIV_1:    ccad_prescale = CCAD_PRE_1;
         CCAD_DIV_8:    ccad_prescale = CCAD_PRE_8;
         CCAD_DIV_64:   ccad_prescale = CCAD_PRE_64;
         CCAD_DIV_1024: ccad_prescale = CCAD_PRE_1024;
      endcase
   endfunction

endpackage

// file: rtl/ccad_mem.sv
// small synchronous memory with registered read data
`timescale 1ns/1ns
`default_nettype none
module ccad_mem #(
   parameter int AW = 6
) (
   input  wire logic          i_mclk,
   input  wire logic          i_we,
   input  wire logic [AW-1:0] i_addr,
   input  wire logic [7:0]    i_wdata,
   output logic [7:0]         o_rdata
);
   logic [7:0] mem_reg [2**AW];

   always_ff @(posedge i_mclk) begin
      if (i_we) begin
         mem_reg[i_addr] <= i_wdata;
      end
   end

   // old contents on a write cycle; reads never see their own write
   always_ff @(posedge i_mclk) begin
      o_rdata <= mem_reg[i_addr];
   end
endmodule // ccad_mem
`default_nettype wire

// file: rtl/ccad_timer.sv
// interval timer: prescaler, 8-bit down counter and interrupt flag
`timescale 1ns/1ns
`default_nettype none
module ccad_timer
   import ccad_pkg::*;
(
   input  wire logic       i_mclk,
   input  wire logic       i_resetn,
   input  wire logic       i_access,
   input  wire logic       i_write,
   input  wire logic [1:0] i_div_sel,
   input  wire logic       i_irq_en,
   input  wire logic [7:0] i_wdata,
   output logic [7:0]      o_count,
   output logic            o_flag,
   output logic            o_irq_en
);
   logic [9:0] pre_reg;
   logic [1:0] sel_reg;
   logic       fast_reg;
   logic       tick;
   logic       raise;

   assign tick  = (pre_reg == CCAD_PRE_1);
   assign raise = tick && !fast_reg && (o_count == 8'h00);

   // ==========================================================
   // prescaler
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         sel_reg <= CCAD_DIV_1;
         pre_reg <= CCAD_PRE_1;
      end else if (i_write) begin
         sel_reg <= i_div_sel;
         pre_reg <= ccad_prescale(i_div_sel);
      end else if (tick) begin
         pre_reg <= ccad_prescale(sel_reg);
      end else begin
         pre_reg <= pre_reg - 10'h001;
      end
   end

   // ==========================================================
   // counter: after underflow it runs at the undivided rate
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_count  <= CCAD_COUNT_RST;
         fast_reg <= 1'b0;
      end else if (i_write) begin
         o_count  <= i_wdata;
         fast_reg <= 1'b0;
      end else begin
         if (fast_reg || tick) begin
            o_count <= o_count - 8'h01;
         end
         if (raise) begin
            fast_reg <= 1'b1;
         end
      end
   end

   // ==========================================================
   // flag: raise wins over a same-cycle access
   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_flag <= 1'b0;
      end else if (raise) begin
         o_flag <= 1'b1;
      end else if (i_access) begin
         o_flag <= 1'b0;
      end
   end

   always_ff @(posedge i_mclk or negedge i_resetn) begin
      if (!i_resetn) begin
         o_irq_en <= 1'b0;
      end else if (i_access) begin
         o_irq_en <= i_irq_en;
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (!i_resetn);

   property p_raise_sets;
      raise |=> o_flag && (o_count == CCAD_WRAP || $past(i_write));
   endproperty
   a_raise_sets: assert property (p_raise_sets) else $error("flag not set on underflow");

   property p_access_clears;
      (i_access && !raise && o_flag) |=> !o_flag;
   endproperty
   a_access_clears: assert property (p_access_clears) else $error("access did not clear flag");

   property p_prescale_load;
      i_write |=> pre_reg == ccad_prescale($past(i_div_sel)) ##1 (sel_reg == $past(i_div_sel, 2) || $past(i_write));
   endproperty
   a_prescale_load: assert property (p_prescale_load) else $error("prescale not loaded");

   property p_irq_en_follow;
      i_access |=> o_irq_en == $past(i_irq_en);
   endproperty
   a_irq_en_follow: assert property (p_irq_en_follow) else $error("irq enable not taken");

   c_raise: cover property (raise);
endmodule // ccad_timer
`default_nettype wire

// file: rtl/ccad_dummy_never.sv
// spare design unit: no logic lives here

// file: test/ccad_pins_model.sv
// peripheral side model: resolves port pins from chip drive, external drivers and pull-ups
`timescale 1ns/1ns
`default_nettype none
module ccad_pins_model
   import ccad_pkg::*;
(
   input  wire ccad_pins_t i_port_a,
   input  wire ccad_pins_t i_port_b,
   input  wire logic [7:0] i_ext_a_en,
   input  wire logic [7:0] i_ext_a,
   input  wire logic [7:0] i_ext_b_en,
   input  wire logic [7:0] i_ext_b,
   output logic [7:0]      o_pins_a,
   output logic [7:0]      o_pins_b
);
   // ==========================================================
   // pin resolution
   // an undriven pin settles at the pull-up level, never at its last value
   assign o_pins_a = (i_port_a.oe & i_port_a.level) | (~i_port_a.oe & ((i_ext_a_en & i_ext_a) | ~i_ext_a_en));
   // chip selects on b5/b6 come from the external drivers
   assign o_pins_b = (i_port_b.oe & i_port_b.level) | (~i_port_b.oe & ((i_ext_b_en & i_ext_b) | ~i_ext_b_en));
endmodule // ccad_pins_model
`default_nettype wire

// file: test/tb.sv
// testbench: bus cycle tasks and directed scenarios for the address decoder
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
   $display("wrong value at %0t: got %h expected %h", $time, (g), (e)); end end
module tb;
   import ccad_pkg::*;
   localparam logic [2:0] CHIP = 3'h2;
   localparam logic [7:0] SEED = 8'h3c;
   logic       mclk     = 1'b0;
   logic       rst_n    = 1'b0;
   ccad_bus_t  bus      = '0;
   logic [7:0] ext_a_en = 8'h0f;
   logic [7:0] ext_a    = 8'h03;
   logic [7:0] ext_b_en = 8'h60;
   logic [7:0] ext_b    = 8'h00;
   logic [7:0] pins_a;
   logic [7:0] pins_b;
   logic [7:0] rdata;
   logic       rd_oe;
   ccad_pins_t pa;
   ccad_pins_t pb;
   logic [7:0] q;
   logic       oe;
   logic [7:0] c1;
   logic [7:0] c2;
   int         mismatches = 0;
   int         n_checks   = 0;

   always #20 mclk = ~mclk;

   ccad_decode #(.CS1_IS_SELECT(1'b1), .CS2_IS_SELECT(1'b1), .ROM_KEY(3'h1), .USE_CHIP_ID(1'b1),
      .CHIP_ID(CHIP), .ROM_SEED(SEED)) ccad_decode_inst (.i_mclk(mclk), .i_resetn(rst_n), .i_bus(bus),
      .i_port_a_pins(pins_a), .i_port_b_pins(pins_b), .o_data(rdata), .o_data_oe(rd_oe),
      .o_port_a(pa), .o_port_b(pb));
   ccad_pins_model ccad_pins_model_inst (.i_port_a(pa), .i_port_b(pb), .i_ext_a_en(ext_a_en), .i_ext_a(ext_a),
      .i_ext_b_en(ext_b_en), .i_ext_b(ext_b), .o_pins_a(pins_a), .o_pins_b(pins_b));

   // ==========================================================
   // helpers
   task automatic final_report();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   function automatic logic [9:0] io(input logic a3, input logic a2, input logic [1:0] sel);
      return {1'b1, CHIP, 2'b00, a3, a2, sel};
   endfunction

   function automatic logic [9:0] ram(input logic [5:0] w);
      return {1'b0, CHIP, w};
   endfunction

   function automatic logic [7:0] rom_w(input logic [9:0] a);
      return a[7:0] ^ {6'h00, a[9:8]} ^ SEED;
   endfunction

   // one access; the answer stands for one cycle, from the edge after the taking edge
   task automatic acc(input logic rd, input logic rs, input logic [9:0] a, input logic [7:0] wd);
      @(negedge mclk);
      bus = '{valid: 1'b1, read: rd, rom_region_select: rs, addr: a, wdata: wd};
      @(posedge mclk);
      @(negedge mclk);
      bus.valid = 1'b0;
      @(posedge mclk);
      @(negedge mclk);
      q = rdata;
      oe = rd_oe;
   endtask

   task automatic wr(input logic rs, input logic [9:0] a, input logic [7:0] wd);
      acc(1'b0, rs, a, wd);
      `CHK(oe, 1'b0)
   endtask

   task automatic rd(input logic rs, input logic [9:0] a, input logic [7:0] e);
      acc(1'b1, rs, a, 8'h00);
      `CHK(oe, 1'b1)
      `CHK(q, e)
   endtask

   task automatic set_cs(input logic cs1, input logic cs2);
      @(negedge mclk);
      ext_b[6] = cs1;
      ext_b[5] = cs2;
   endtask

   // ==========================================================
   // scenarios
   initial begin
      repeat (2) @(negedge mclk);
      `CHK(rd_oe, 1'b0)
      `CHK(pa.level, 8'hff)
      `CHK(pa.oe, 8'h00)
      repeat (2) @(negedge mclk);
      rst_n = 1'b1;
      wr(1'b0, ram(6'h00), 8'h11);
      wr(1'b0, ram(6'h05), 8'h55);
      wr(1'b0, ram(6'h3f), 8'hee);
      rd(1'b0, ram(6'h00), 8'h11);
      rd(1'b0, ram(6'h3f), 8'hee);
      rd(1'b1, ram(6'h05), rom_w(ram(6'h05)));
      wr(1'b1, ram(6'h05), 8'hff);
      rd(1'b0, ram(6'h05), 8'h55);
      rd(1'b1, 10'h3c0, rom_w(10'h3c0));
      // wrong chip number and raised chip selects must leave ram alone
      wr(1'b0, {1'b0, 3'h5, 6'h05}, 8'h99);
      set_cs(1'b1, 1'b0);
      wr(1'b0, ram(6'h05), 8'h77);
      acc(1'b1, 1'b0, ram(6'h05), 8'h00);
      `CHK(oe, 1'b0)
      set_cs(1'b0, 1'b1);
      wr(1'b0, ram(6'h05), 8'h66);
      acc(1'b1, 1'b1, ram(6'h05), 8'h00);
      `CHK(oe, 1'b0)
      set_cs(1'b0, 1'b0);
      rd(1'b0, ram(6'h05), 8'h55);
      // seven-chip wiring: a12, a11, a10 onto the two selects and rom select; only chip one answers
      for (int k = 1; k < 8; k++) begin
         set_cs(k[1], k[2]);
         acc(1'b1, k[0], 10'h155, 8'h00);
         `CHK(oe, (k == 1))
      end
      set_cs(1'b0, 1'b0);
      // ports
      wr(1'b0, io(1'b0, 1'b0, CCAD_PA_DIR), 8'hf0);
      wr(1'b0, io(1'b0, 1'b0, CCAD_PA_DATA), 8'ha5);
      `CHK(pa.oe, 8'hf0)
      `CHK(pa.level, 8'haf)
      rd(1'b0, io(1'b0, 1'b0, CCAD_PA_DATA), 8'ha3);
      rd(1'b0, io(1'b0, 1'b0, CCAD_PA_DIR), 8'hf0);
      `CHK(pa.level, 8'haf)
      wr(1'b0, io(1'b0, 1'b0, CCAD_PB_DIR), 8'h03);
      wr(1'b0, io(1'b0, 1'b0, CCAD_PB_DATA), 8'h02);
      `CHK(pb.oe, 8'h03)
      rd(1'b0, io(1'b0, 1'b0, CCAD_PB_DATA), 8'h9e);
      rd(1'b0, io(1'b0, 1'b0, CCAD_PB_DIR), 8'h03);
      // timer count reads three cycles apart, a1 ignored
      wr(1'b0, io(1'b0, 1'b1, CCAD_DIV_1), 8'h80);
      acc(1'b1, 1'b0, io(1'b0, 1'b1, 2'h0), 8'h00);
      c1 = q;
      acc(1'b1, 1'b0, io(1'b0, 1'b1, 2'h2), 8'h00);
      c2 = q;
      `CHK(c1[7:4], 4'h7)
      `CHK(c1 - c2, 8'h03)
      // every prescaler: count of one, flag not early (divide by 8 and up), set late, cleared by access
      for (int s = 0; s < 4; s++) begin
         int   dv;
         logic a3;
         dv = 1 << ((s == 3) ? 10 : 3 * s);
         a3 = s[0];
         wr(1'b0, io(a3, 1'b1, s[1:0]), 8'h01);
         if (dv >= 8) begin
            repeat (dv / 2) @(posedge mclk);
            rd(1'b0, io(a3, 1'b1, 2'h1), 8'h00);
         end
         repeat (2 * dv + 4) @(posedge mclk);
         @(negedge mclk);
         `CHK(pb.oe[7], a3)
         `CHK(pb.level[7], ~a3)
         rd(1'b0, io(a3, 1'b1, 2'h3), 8'h80);
         `CHK(pb.oe[7], 1'b0)
         rd(1'b0, io(a3, 1'b1, 2'h1), 8'h00);
      end
      final_report();
   end

   // hang guard
   initial begin
      repeat (60000) @(posedge mclk);
      mismatches++;
      final_report();
   end
endmodule // tb
`default_nettype wire
